// >>> verilog/remote_local_status_control.sv
// Notes on behaviour
// - numeric parameters longer than 30 characters are rejected.
// - in local, queries run; state-changing commands dropped silently.
// - in local-lockout a remote command goes to remote-lockout.
// - local goes remote on listen address with REN, or serial remote.
// - remote ignores keys but Escape; Escape, GTL, serial local give local.
// - remote-lockout: Escape ignored; GTL to local-lockout; REN falling or local to local.
// - LLO with REN or serial lockout: local to local-lockout, remote to remote-lockout.
// - local never jumps straight to remote-lockout.
// - missing or bad number sets command error; serial gets unrecognised reply.
// - out-of-range number sets execution error; serial gets invalid reply.
// - clear-status clears event flags and resets operation-complete logic.
// - summary bit set when event register AND mask is non-zero.
// - mask write accepts 0 to 255 only; mask is zero after reset.
// - mask query returns current mask in 0 to 255.
// - reading the event register returns it and clears it.
// - day 1-31, month 1-12, hour 0-23, minute and second 0-59.
// - keywords match case-blind with at least the upper-case letters.
// - event register bits: command error 5, execution error 4, opc 0, power-on 7.
// - status byte: summary bit 5, request-service bit 6.
`timescale 1ns/1ps
`default_nettype none
module remote_local_status_control
    import remote_local_pkg::*;
(
    input  wire logic                   clock,
    input  wire logic                   rstn,
    // interface messages, one-cycle pulses except ren
    input  wire logic                   ren,
    input  wire logic                   listen_addressed,
    input  wire logic                   llo_msg,
    input  wire logic                   gtl_msg,
    // serial commands, one-cycle pulses
    input  wire logic                   serial_remote_cmd,
    input  wire logic                   serial_local_cmd,
    input  wire logic                   serial_lockout_cmd,
    // front panel
    input  wire logic                   key_press,
    input  wire logic                   key_is_escape,
    output logic                        key_accept,
    // decoded command from the keyword matcher
    input  wire logic                   cmd_valid,
    input  wire logic                   cmd_changes_state,
    input  wire logic                   cmd_from_serial,
    input  wire logic                   cmd_keyword_ok,
    input  wire logic                   clear_status_command,
    input  wire logic                   mask_write,
    input  wire logic                   mask_query,
    input  wire logic                   esr_query,
    input  wire logic                   opc_command,
    input  wire logic                   query_error,
    input  wire logic [2:0]             param_field,
    // numeric parameter characters
    input  wire logic                   num_start,
    input  wire logic                   num_valid,
    input  wire logic [7:0]             num_char,
    input  wire logic                   num_last,
    input  wire logic                   num_missing,
    // results
    output logic                        cmd_execute,
    output logic                        cmd_discard,
    output logic                        param_valid,
    output logic [NUM_VALUE_W-1:0]      param_value,
    output logic                        reply_unrecognised,
    output logic                        reply_invalid,
    output logic                        query_valid,
    output logic [7:0]                  query_data,
    output logic [7:0]                  event_status_reg,
    output logic [7:0]                  event_enable_mask,
    output logic [7:0]                  status_byte,
    output logic                        opc_idle,
    output logic [1:0]                  remote_state
);
    // ------------------------------------------------------------
    // remote / local state machine
    // ------------------------------------------------------------
    rl_state_type  rl_reg;
    rl_state_type  rl_next;
    logic          go_remote;
    logic          go_lock;
    logic          ren_reg;

    assign go_remote = (ren && listen_addressed) || serial_remote_cmd;
    assign go_lock   = (ren && llo_msg) || serial_lockout_cmd;

    always_comb begin
        rl_next = rl_reg;
        case (rl_reg)
            ST_LOCAL: begin
                // lockout takes priority so both together never skip to remote-lockout
                if (go_lock)
                    rl_next = ST_LOCAL_LOCK;
                else if (go_remote)
                    rl_next = ST_REMOTE;
            end
            ST_REMOTE: begin
                if (ren_reg && !ren && !serial_remote_cmd && !go_lock)
                    rl_next = ST_LOCAL;
                else if (gtl_msg || serial_local_cmd || (key_press && key_is_escape))
                    rl_next = ST_LOCAL;
                else if (go_lock)
                    rl_next = ST_REMOTE_LOCK;
            end
            ST_LOCAL_LOCK: begin
                if (go_remote)
                    rl_next = ST_REMOTE_LOCK;
            end
            ST_REMOTE_LOCK: begin
                if ((ren_reg && !ren && !serial_lockout_cmd && !serial_remote_cmd) || serial_local_cmd)
                    rl_next = ST_LOCAL;
                else if (gtl_msg)
                    rl_next = ST_LOCAL_LOCK;
            end
            default: begin
                rl_next = ST_LOCAL;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        ren_reg <= ren;
        if (!rstn)
            rl_reg <= ST_LOCAL;
        else
            rl_reg <= rl_next;
    end

    assign remote_state = rl_reg;
    // escape never passes in remote-lockout; it is consumed by the state change in remote
    assign key_accept = key_press && (rl_reg == ST_LOCAL || rl_reg == ST_LOCAL_LOCK);

    // ------------------------------------------------------------
    // command gating
    // ------------------------------------------------------------
    logic  in_local;
    assign in_local = (rl_reg == ST_LOCAL) || (rl_reg == ST_LOCAL_LOCK);

    always_ff @(posedge clock) begin
        if (!rstn) begin
            cmd_execute <= 1'b0;
            cmd_discard <= 1'b0;
        end else begin
            // keyword matching itself is done case-blind upstream and arrives as cmd_keyword_ok
            cmd_execute <= cmd_valid && cmd_keyword_ok && !(in_local && cmd_changes_state);
            cmd_discard <= cmd_valid && cmd_keyword_ok && in_local && cmd_changes_state;
        end
    end

    // ------------------------------------------------------------
    // numeric parameter checking
    // ------------------------------------------------------------
    logic                    np_done;
    logic                    np_ok;
    logic [NUM_VALUE_W-1:0]  np_value;
    logic                    np_int;
    logic                    in_range;
    logic [7:0]              v8;
    logic                    fits8;
    field_type               field;

    number_parser u_parser (
        .clock      (clock),
        .rstn       (rstn),
        .start      (num_start),
        .char_valid (num_valid),
        .char_data  (num_char),
        .char_last  (num_last),
        .done       (np_done),
        .ok         (np_ok),
        .value      (np_value),
        .is_integer (np_int)
    );

    assign field = field_type'(param_field);
    assign fits8 = np_value <= MASK_MAX;
    assign v8    = np_value[7:0];

    always_comb begin
        case (field)
            FLD_DAY:    in_range = fits8 && v8 >= DAY_MIN && v8 <= DAY_MAX;
            FLD_MONTH:  in_range = fits8 && v8 >= MONTH_MIN && v8 <= MONTH_MAX;
            FLD_HOUR:   in_range = fits8 && v8 <= HOUR_MAX;
            FLD_MINSEC: in_range = fits8 && v8 <= MIN_SEC_MAX;
            FLD_MASK:   in_range = fits8;
            default:    in_range = 1'b1;
        endcase
    end

    logic  bad_form;
    logic  bad_range;
    assign bad_form  = (np_done && !np_ok) || num_missing;
    // range-limited fields take integers only
    assign bad_range = np_done && np_ok && (!in_range || (field != FLD_NONE && !np_int));

    always_ff @(posedge clock) begin
        if (!rstn) begin
            param_valid        <= 1'b0;
            param_value        <= '0;
            reply_unrecognised <= 1'b0;
            reply_invalid      <= 1'b0;
        end else begin
            param_valid        <= np_done && np_ok && !bad_range;
            if (np_done)
                param_value <= np_value;
            reply_unrecognised <= bad_form && cmd_from_serial;
            reply_invalid      <= bad_range && cmd_from_serial;
        end
    end

    // ------------------------------------------------------------
    // event enable mask
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rstn)
            event_enable_mask <= MASK_RESET;
        else if (mask_write && param_valid && field == FLD_MASK)
            event_enable_mask <= param_value[7:0];
    end

    // ------------------------------------------------------------
    // event status register
    // ------------------------------------------------------------
    logic [7:0]  esr_set;

    always_comb begin
        esr_set                = 8'h00;
        esr_set[CMD_ERR_BIT]   = bad_form;
        esr_set[EXEC_ERR_BIT]  = bad_range;
        esr_set[OPC_BIT]       = opc_command;
        esr_set[QUERY_ERR_BIT] = query_error;
        esr_set[USER_REQ_BIT]  = key_press;
    end

    always_ff @(posedge clock) begin
        if (!rstn)
            event_status_reg <= ESR_RESET;
        else if (clear_status_command || esr_query)
            event_status_reg <= esr_set;
        else
            event_status_reg <= event_status_reg | esr_set;
    end

    always_ff @(posedge clock) begin
        if (!rstn)
            opc_idle <= 1'b1;
        else if (clear_status_command)
            opc_idle <= 1'b1;
        else if (opc_command)
            opc_idle <= 1'b0;
    end

    // ------------------------------------------------------------
    // queries and status byte
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rstn) begin
            query_valid <= 1'b0;
            query_data  <= 8'h00;
        end else begin
            query_valid <= mask_query || esr_query;
            if (esr_query)
                query_data <= event_status_reg;
            else if (mask_query)
                query_data <= event_enable_mask;
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn)
            status_byte <= 8'h00;
        else begin
            status_byte          <= 8'h00;
            status_byte[ESB_BIT] <= |(event_status_reg & event_enable_mask);
            status_byte[RQS_BIT] <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// >>> verilog/remote_local_pkg.sv
package remote_local_pkg;

    // ------------------------------------------------------------
    // event status register layout
    // ------------------------------------------------------------
    localparam int          OPC_BIT           = 0;
    localparam int          QUERY_ERR_BIT     = 2;
    localparam int          EXEC_ERR_BIT      = 4;
    localparam int          CMD_ERR_BIT       = 5;
    localparam int          USER_REQ_BIT      = 6;
    localparam int          PON_BIT           = 7;
    localparam logic [7:0]  ESR_RESET         = 8'h80;
    localparam logic [7:0]  MASK_RESET        = 8'h00;

    // ------------------------------------------------------------
    // status byte layout
    // ------------------------------------------------------------
    localparam int          ESB_BIT           = 5;
    localparam int          RQS_BIT           = 6;

    // ------------------------------------------------------------
    // number parser limits
    // ------------------------------------------------------------
    localparam int          MAX_NUM_CHARS     = 30;
    localparam int          NUM_VALUE_W       = 32;
    localparam logic [31:0] MASK_MAX          = 32'h000000FF;

    // ------------------------------------------------------------
    // date and time ranges
    // ------------------------------------------------------------
    localparam logic [7:0]  DAY_MIN           = 8'h01;
    localparam logic [7:0]  DAY_MAX           = 8'h1F;
    localparam logic [7:0]  MONTH_MIN         = 8'h01;
    localparam logic [7:0]  MONTH_MAX         = 8'h0C;
    localparam logic [7:0]  HOUR_MAX          = 8'h17;
    localparam logic [7:0]  MIN_SEC_MAX       = 8'h3B;

    // ------------------------------------------------------------
    // enumerations
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_LOCAL        = 2'b00,
        ST_REMOTE       = 2'b01,
        ST_LOCAL_LOCK   = 2'b10,
        ST_REMOTE_LOCK  = 2'b11
    } rl_state_type;

    typedef enum logic [2:0] {
        FLD_NONE   = 3'b000,
        FLD_DAY    = 3'b001,
        FLD_MONTH  = 3'b010,
        FLD_HOUR   = 3'b011,
        FLD_MINSEC = 3'b100,
        FLD_MASK   = 3'b101
    } field_type;

    typedef enum logic [2:0] {
        NP_IDLE  = 3'b000,
        NP_SIGN  = 3'b001,
        NP_INT   = 3'b010,
        NP_FRAC  = 3'b011,
        NP_EXP   = 3'b100,
        NP_EXPSG = 3'b101,
        NP_EXPD  = 3'b110,
        NP_BAD   = 3'b111
    } np_state_type;

endpackage

// >>> verilog/number_parser.sv
`timescale 1ns/1ps
`default_nettype none
module number_parser
    import remote_local_pkg::*;
(
    input  wire logic                   clock,
    input  wire logic                   rstn,
    input  wire logic                   start,
    input  wire logic                   char_valid,
    input  wire logic [7:0]             char_data,
    input  wire logic                   char_last,
    output logic                        done,
    output logic                        ok,
    output logic [NUM_VALUE_W-1:0]      value,
    output logic                        is_integer
);
    // ------------------------------------------------------------
    // character scanner
    // ------------------------------------------------------------
    np_state_type              state_reg;
    np_state_type              state_next;
    logic [5:0]                count_reg;
    logic [NUM_VALUE_W-1:0]    acc_reg;
    logic                      digits_reg;
    logic                      int_reg;
    logic                      is_digit;
    logic [NUM_VALUE_W-1:0]    acc_next;

    assign is_digit = (char_data >= 8'h30) && (char_data <= 8'h39);
    assign acc_next = NUM_VALUE_W'(acc_reg * 32'h0000000A) + {24'h000000, char_data - 8'h30};

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            NP_IDLE, NP_SIGN: begin
                if (is_digit)
                    state_next = NP_INT;
                else if (char_data == 8'h2E && state_reg == NP_IDLE)
                    state_next = NP_FRAC;
                else if ((char_data == 8'h2B || char_data == 8'h2D) && state_reg == NP_IDLE)
                    state_next = NP_SIGN;
                else
                    state_next = NP_BAD;
            end
            NP_INT, NP_FRAC: begin
                if (is_digit)
                    state_next = state_reg;
                else if (char_data == 8'h2E && state_reg == NP_INT)
                    state_next = NP_FRAC;
                else if ((char_data == 8'h45 || char_data == 8'h65) && digits_reg)
                    state_next = NP_EXP;
                else
                    state_next = NP_BAD;
            end
            NP_EXP: begin
                if (is_digit)
                    state_next = NP_EXPD;
                else if (char_data == 8'h2B || char_data == 8'h2D)
                    state_next = NP_EXPSG;
                else
                    state_next = NP_BAD;
            end
            NP_EXPSG, NP_EXPD: begin
                state_next = is_digit ? NP_EXPD : NP_BAD;
            end
            NP_BAD: begin
                state_next = NP_BAD;
            end
            default: begin
                state_next = NP_BAD;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rstn || start) begin
            state_reg  <= NP_IDLE;
            count_reg  <= 6'h00;
            acc_reg    <= '0;
            digits_reg <= 1'b0;
            int_reg    <= 1'b1;
        end else if (char_valid) begin
            state_reg <= state_next;
            if (count_reg == 6'(MAX_NUM_CHARS))
                state_reg <= NP_BAD;
            else
                count_reg <= count_reg + 6'h01;
            if (is_digit && (state_reg == NP_IDLE || state_reg == NP_SIGN || state_reg == NP_INT)) begin
                acc_reg    <= acc_next;
                digits_reg <= 1'b1;
            end else if (is_digit && state_reg == NP_FRAC) begin
                digits_reg <= 1'b1;
            end
            if (state_next != NP_INT && state_next != NP_IDLE)
                int_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // result
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rstn) begin
            done       <= 1'b0;
            ok         <= 1'b0;
            value      <= '0;
            is_integer <= 1'b0;
        end else begin
            done <= char_valid && char_last && !start;
            if (char_valid && char_last && !start) begin
                // an exponent with no digits, or no mantissa digits, is malformed
                ok <= (state_next == NP_INT || state_next == NP_FRAC || state_next == NP_EXPD)
                      && (digits_reg || is_digit) && count_reg < 6'(MAX_NUM_CHARS);
                value      <= (state_next == NP_INT && is_digit) ? acc_next : acc_reg;
                is_integer <= int_reg && state_next == NP_INT;
            end
        end
    end
endmodule
`default_nettype wire

// >>> test/remote_local_status_control_properties.sv
`timescale 1ns/1ps
`default_nettype none
module remote_local_status_control_properties
    import remote_local_pkg::*;
(
    input wire logic       clock,
    input wire logic       rstn,
    input wire logic       ren,
    input wire logic       llo_msg,
    input wire logic       gtl_msg,
    input wire logic       serial_local_cmd,
    input wire logic       serial_lockout_cmd,
    input wire logic       key_press,
    input wire logic       key_is_escape,
    input wire logic       cmd_valid,
    input wire logic       cmd_changes_state,
    input wire logic       clear_status_command,
    input wire logic       mask_write,
    input wire logic       esr_query,
    input wire logic       cmd_discard,
    input wire logic       query_valid,
    input wire logic [7:0] query_data,
    input wire logic [7:0] event_status_reg,
    input wire logic [7:0] event_enable_mask,
    input wire logic [7:0] status_byte,
    input wire logic [1:0] remote_state
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);

    // ------------------------------------------------------------
    // remote and local states
    // ------------------------------------------------------------
    a_no_lock_jump: assert property (remote_state == 2'h0 |=> remote_state != 2'h3)
        else $error("local went straight to remote lockout");
    a_local_discard: assert property (cmd_valid && cmd_changes_state && !remote_state[0] |=> cmd_discard)
        else $error("state change not discarded in local");
    a_escape_locked: assert property (remote_state == 2'h3 && key_press && key_is_escape && ren && !gtl_msg
        && !serial_local_cmd |=> remote_state == 2'h3)
        else $error("escape left remote lockout");
    a_escape_remote: assert property (remote_state == 2'h1 && key_press && key_is_escape && ren && !llo_msg
        && !serial_lockout_cmd |=> remote_state == 2'h0)
        else $error("escape did not return to local");
    a_gtl_lockout: assert property (remote_state == 2'h3 && gtl_msg && ren && !serial_local_cmd
        |=> remote_state == 2'h2)
        else $error("go to local missed local lockout");
    a_ren_release: assert property (remote_state == 2'h3 && $fell(ren) |=> remote_state == 2'h0)
        else $error("remote enable drop did not give local");

    // ------------------------------------------------------------
    // status registers
    // ------------------------------------------------------------
    a_summary_bit: assert property (1'b1 |=> status_byte[ESB_BIT] == |($past(event_status_reg & event_enable_mask)))
        else $error("summary bit wrong");
    a_mask_hold: assert property ($changed(event_enable_mask) |-> $past(mask_write))
        else $error("enable mask changed without a write");
    a_flags_sticky: assert property (|($past(event_status_reg) & ~event_status_reg)
        |-> $past(esr_query | clear_status_command))
        else $error("event flag dropped without read or clear");
    a_esr_readback: assert property (esr_query |=> query_valid && query_data == $past(event_status_reg))
        else $error("event register read returned wrong data");

    c_remote_lock: cover property (remote_state == 2'h3);
    c_discard: cover property (cmd_discard);
    c_summary: cover property (status_byte[ESB_BIT]);
    c_query: cover property (query_valid);
endmodule
bind remote_local_status_control remote_local_status_control_properties chk (.*);
`default_nettype wire

// >>> test/controller_model.sv
`timescale 1ns/1ps
`default_nettype none
module controller_model (
    input  wire logic       clock,
    input  wire logic       op_valid,
    input  wire logic [2:0] op,
    output var logic        ren,
    output var logic        listen_addressed,
    output var logic        llo_msg,
    output var logic        gtl_msg,
    output var logic        serial_remote_cmd,
    output var logic        serial_local_cmd,
    output var logic        serial_lockout_cmd
);
    initial ren = 1'b0;
    // messages leave as one-cycle pulses; remote enable is a level
    always @(posedge clock) begin
        if (op_valid && op[2:1] == 2'b00) begin
            ren <= !op[0];
        end
        listen_addressed <= op_valid && op == 3'h2 && ren;
        llo_msg <= op_valid && op == 3'h3 && ren;
        gtl_msg <= op_valid && op == 3'h4;
        serial_remote_cmd <= op_valid && op == 3'h5;
        serial_local_cmd <= op_valid && op == 3'h6;
        serial_lockout_cmd <= op_valid && op == 3'h7;
    end
endmodule
`default_nettype wire

// >>> test/remote_local_status_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
    $display("mismatch at %0t got %h exp %h", $time, g, e); end end
module remote_local_status_control_bench import remote_local_pkg::*;;
    logic        clock = 1'b0, rstn = 1'b0, op_valid = 1'b0, key_press = 1'b0, key_is_escape = 1'b0;
    logic [2:0]  op = 3'h0, param_field = 3'h0;
    logic        ren, listen_addressed, llo_msg, gtl_msg, serial_remote_cmd, serial_local_cmd, serial_lockout_cmd;
    logic        cmd_valid = 1'b0, clear_status_command = 1'b0, mask_write = 1'b0, mask_query = 1'b0;
    logic        esr_query = 1'b0, opc_command = 1'b0, num_start = 1'b0, num_valid = 1'b0;
    logic        num_last = 1'b0, num_missing = 1'b0;
    logic [7:0]  num_char = 8'h00;
    // upstream matcher is not modelled, so its qualifiers are tied
    logic        cmd_changes_state = 1'b1, cmd_from_serial = 1'b0, cmd_keyword_ok = 1'b1, query_error = 1'b0;
    logic        key_accept, cmd_execute, cmd_discard, param_valid, reply_unrecognised, reply_invalid;
    logic        query_valid, opc_idle;
    logic [31:0] param_value;
    logic [7:0]  query_data, event_status_reg, event_enable_mask, status_byte, exp_v;
    logic [1:0]  remote_state;
    int          n_mismatch = 0, cmp_count = 0, cycles = 0;
    logic [7:0]  expq[$];
    logic [15:0] lfsr_q = 16'h3ED5;
    int          ops[13] = '{0, 2, 3, 8, 4, 2, 1, 1, 5, 8, 7, 5, 6};
    logic [1:0]  st[13] = '{2'h0, 2'h1, 2'h3, 2'h3, 2'h2, 2'h3, 2'h0, 2'h0, 2'h1, 2'h0, 2'h2, 2'h3, 2'h0};
    string       cs[12] = '{"1234D-1", "123.4 e00", "n123.4", "e34", "0000123.4",
                            "1111111111111111111111111111111", "000000000000000000000000000001",
                            "32", "0", "12", "24", "300"};
    logic [2:0]  cf[12] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h1, 3'h1, 3'h2, 3'h3, 3'h5};
    logic [7:0]  ce[12] = '{8'h60, 8'h20, 8'h20, 8'h20, 8'h00, 8'h20, 8'h00, 8'h10, 8'h10, 8'h00, 8'h10, 8'h10};

    controller_model far_side (.*);
    remote_local_status_control uut (.*);

    initial forever #5 clock = ~clock;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] nxt(logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction

    task automatic tick();
        @(posedge clock);
        #1;
    endtask

    task automatic done(string nm);
        $display("test %s done", nm);
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic ctl(int k, logic [1:0] e);
        tick();
        key_press = (k == 8);
        key_is_escape = (k == 8);
        op_valid = (k != 8);
        op = k[2:0];
        tick();
        key_press = 1'b0;
        op_valid = 1'b0;
        tick();
        tick();
        `CHK(remote_state, e)
    endtask

    // numbers include malformed and out-of-range cases; the 31-character one is a deliberate refusal, the 30-character one passes
    task automatic num(string s, logic [2:0] f, logic w);
        tick();
        num_start = 1'b1;
        param_field = f;
        for (int i = 0; i < s.len(); i++) begin
            tick();
            num_start = 1'b0;
            num_valid = 1'b1;
            num_char = s[i];
            num_last = (i == s.len() - 1);
        end
        tick();
        num_valid = 1'b0;
        num_last = 1'b0;
        tick();
        mask_write = w;
        tick();
        mask_write = 1'b0;
    endtask

    task automatic q(logic kind, logic [7:0] e);
        tick();
        expq.push_back(e);
        esr_query = !kind;
        mask_query = kind;
        tick();
        esr_query = 1'b0;
        mask_query = 1'b0;
        tick();
    endtask

    always @(posedge clock) begin
        if (query_valid === 1'b1) begin
            exp_v = expq.pop_front();
            `CHK(query_data, exp_v)
        end
    end

    always @(posedge clock) begin
        cycles++;
        if (cycles == 4000) begin
            n_mismatch++;
            end_of_test();
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (6) @(posedge clock);
        #1 rstn = 1'b1;
        `CHK(remote_state, 2'h0)
        `CHK(event_enable_mask, 8'h00)
        `CHK(event_status_reg, 8'h80)
        q(1'b0, 8'h80);
        q(1'b0, 8'h00);
        done("reset");
        for (int i = 0; i < 13; i++) ctl(ops[i], st[i]);
        tick();
        cmd_valid = 1'b1;
        tick();
        cmd_valid = 1'b0;
        `CHK(cmd_discard, 1'b1)
        done("states");
        for (int i = 0; i < 12; i++) begin
            num(cs[i], cf[i], 1'b0);
            q(1'b0, ce[i]);
        end
        tick();
        num_missing = 1'b1;
        tick();
        num_missing = 1'b0;
        q(1'b0, 8'h20);
        done("numbers");
        lfsr_q = nxt(lfsr_q);
        num($sformatf("%0d", lfsr_q[7:0]), 3'h5, 1'b1);
        q(1'b1, lfsr_q[7:0]);
        num("32", 3'h5, 1'b1);
        num("e34", 3'h0, 1'b0);
        tick();
        `CHK(status_byte[ESB_BIT], 1'b1)
        done("mask");
        clear_status_command = 1'b1;
        tick();
        clear_status_command = 1'b0;
        q(1'b0, 8'h00);
        `CHK(status_byte[ESB_BIT], 1'b0)
        opc_command = 1'b1;
        tick();
        opc_command = 1'b0;
        q(1'b0, 8'h01);
        done("clear");
        end_of_test();
    end
endmodule
`default_nettype wire
